// ===== shared/lcsd_cfg.svh
`ifndef LCSD_CFG_SVH
`define LCSD_CFG_SVH

// display ram geometry
`define LCSD_RAM_DEPTH     35
`define LCSD_ADDR_W        6
`define LCSD_LAST_ADDR     6'h22
`define LCSD_FIRST_ADDR    6'h00

// command selector codes
`define LCSD_OP2_MODE      2'h2
`define LCSD_OP2_ADDR      2'h0
`define LCSD_OP2_DRIVE     2'h1
`define LCSD_OP4_SETUP     4'hd
`define LCSD_OP4_BLINK     4'he
`define LCSD_OP5_PIXEL     5'h1f

// command field positions
`define LCSD_BIT_FLAG      7
`define LCSD_BIT_DISP_ON   3
`define LCSD_BIT_BIAS      2
`define LCSD_BIT_INVERT    2
`define LCSD_BIT_ADDR_MSB  2
`define LCSD_BIT_SW_RESET  1
`define LCSD_BIT_EXT_CLK   0
`define LCSD_BIT_ALL_ON    1
`define LCSD_BIT_ALL_OFF   0

// setting values after any reset
`define LCSD_RST_RATE      2'h0
`define LCSD_RST_POWER     2'h2
`define LCSD_RST_BLINK     2'h0

// serial bit positions where a nibble is complete
`define LCSD_NIB_HI_CNT    3'h3
`define LCSD_NIB_LO_CNT    3'h7

`endif

// ===== shared/lcsd_pkg.sv
package lcsd_pkg;

  // what the next byte on the link will be
  typedef enum logic [0:0] {
    LCSD_NEXT_CMD  = 1'b0,
    LCSD_NEXT_DATA = 1'b1
  } lcsd_next_t;

  // frame-scoped link state, cleared while the link is deselected
  typedef struct packed {
    logic [2:0] count;
    lcsd_next_t next_kind;
    logic [6:0] shift;
  } lcsd_link_t;

  // hand-over word towards the core clock
  typedef struct packed {
    logic       toggle;
    logic       is_cmd;
    logic [7:0] data;
  } lcsd_hand_t;

  // complete core state
  typedef struct packed {
    logic              tg1;
    logic              tg2;
    logic              tg3;
    logic              inh1;
    logic              inh2;
    logic              disp_on;
    logic              bias_half;
    logic [1:0]        rate;
    logic              invert;
    logic [1:0]        power;
    logic              addr_msb;
    logic              ext_clk;
    logic [1:0]        blink;
    logic              all_on;
    logic              all_off;
    logic [5:0]        addr;
    logic [34:0][3:0]  ram;
    logic [139:0]      pixel;
  } lcsd_core_t;

endpackage

// ===== hw/lcsd_link_rx.sv
`timescale 1ns/1ps
`include "lcsd_cfg.svh"

// serial receiver on the link clock; emits command bytes and data nibbles
module lcsd_link_rx
  import lcsd_pkg::*;
(
  input  wire logic       scl,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       serial_data_in,
  output logic            ev_toggle,
  output logic            ev_is_cmd,
  output logic [7:0]      ev_data
);

  lcsd_link_t s;          // frame-scoped state
  lcsd_link_t n;          // its next value
  lcsd_hand_t h;          // hand-over word, survives deselect
  lcsd_hand_t next_h;     // its next value
  logic       frame_rst_n; // low while deselected or in reset
  logic [7:0] full;       // byte including the bit now arriving

  // deselect holds the bit counter in its initial state
  assign frame_rst_n = rst_n & ~cs_n;

  // shift, count, and decide what completes on this edge
  always_comb
  begin
    n      = s;
    next_h = h;
    full   = {s.shift, serial_data_in};
    n.shift = full[6:0];
    n.count = s.count + 3'h1;
    if (s.next_kind == LCSD_NEXT_DATA)
    begin
      // a nibble is only handed on once all four bits arrived
      if (s.count == `LCSD_NIB_HI_CNT || s.count == `LCSD_NIB_LO_CNT)
      begin
        next_h.toggle = ~h.toggle;
        next_h.is_cmd = 1'b0;
        next_h.data   = {4'h0, full[3:0]};
      end
    end
    else if (s.count == `LCSD_NIB_LO_CNT)
    begin
      // command byte complete; its flag names the following byte
      next_h.toggle = ~h.toggle;
      next_h.is_cmd = 1'b1;
      next_h.data   = full;
      n.next_kind   = full[`LCSD_BIT_FLAG] ? LCSD_NEXT_CMD : LCSD_NEXT_DATA;
    end
  end

  // frame state, cleared asynchronously by deselect
  always_ff @(posedge scl or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      s <= '{count: 3'h0, next_kind: LCSD_NEXT_CMD, shift: 7'h00};
    end
    else
    begin
      s <= n;
    end
  end

  // hand-over word, only the device reset clears it
  always_ff @(posedge scl or negedge rst_n)
  begin
    if (!rst_n)
    begin
      h <= '{toggle: 1'b0, is_cmd: 1'b0, data: 8'h00};
    end
    else
    begin
      h <= next_h;
    end
  end

  assign ev_toggle = h.toggle;
  assign ev_is_cmd = h.is_cmd;
  assign ev_data   = h.data;

endmodule

// ===== hw/lcsd_top.sv
`timescale 1ns/1ps
`include "lcsd_cfg.svh"

// Function
// - byte flag says what next byte is
// - mode command sets display on and bias
// - address command loads low five address bits
// - drive command sets frame rate, inversion
// - drive command sets power mode
// - setup command stores address top bit
// - setup command bit one does software reset
// - setup command picks internal or external clock
// - blink command sets blink rate
// - pixel command forces all on or off
// - deselect holds bit counter, blocks input
// - sample rising edge, byte after eighth
// - display ram is 35 by 4 bits
// - address advances after every nibble written
// - address wraps from last to zero
// - address n drives segment n, bit commons
// - partial nibble at deselect is dropped
// - unconnected segment addresses stay writable
// - software reset restores settings, keeps ram
// - inhibit low blanks the display
module lcsd_top
(
  input  wire logic          MCLK,
  input  wire logic          RST_N,
  input  wire logic          SERIAL_CLOCK,
  input  wire logic          CHIP_SELECT_N,
  input  wire logic          SERIAL_DATA_IN,
  input  wire logic          DISPLAY_INHIBIT_N,
  output logic [139:0]       PIXEL,
  output logic               DISPLAY_ON,
  output logic               BIAS_HALF,
  output logic [1:0]         FRAME_RATE,
  output logic               FRAME_INVERSION,
  output logic [1:0]         POWER_MODE,
  output logic               EXT_CLOCK_SEL,
  output logic [1:0]         BLINK_RATE,
  output logic [5:0]         RAM_ADDRESS
);

  import lcsd_pkg::*;

  lcsd_core_t s;            // registered core state
  lcsd_core_t n;            // next core state
  logic       ev_toggle;    // event toggle from the link side
  logic       ev_is_cmd;    // held word is a command
  logic [7:0] ev_data;      // held command byte or nibble
  logic       ev;           // one-cycle pulse: new word arrived
  logic       cmd_ev;       // command byte arrived
  logic       nib_ev;       // data nibble arrived
  logic [7:0] cmd;          // short alias of the held word
  logic       is_mode;      // decoded mode command
  logic       is_addr;      // decoded address command
  logic       is_drive;     // decoded drive command
  logic       is_setup;     // decoded setup command
  logic       is_blink;     // decoded blink command
  logic       is_pixel;     // decoded all-pixel command
  logic       sw_reset;     // setup command asking for reset

  // serial receiver on the link clock
  lcsd_link_rx u_link
  (
    .scl            (SERIAL_CLOCK),
    .rst_n          (RST_N),
    .cs_n           (CHIP_SELECT_N),
    .serial_data_in (SERIAL_DATA_IN),
    .ev_toggle      (ev_toggle),
    .ev_is_cmd      (ev_is_cmd),
    .ev_data        (ev_data)
  );

  // event detect on the synchronised toggle; tg1 feeds only tg2
  assign ev     = s.tg2 ^ s.tg3;
  assign cmd_ev = ev & ev_is_cmd;
  assign nib_ev = ev & ~ev_is_cmd;
  assign cmd    = ev_data;

  // command decode; the held word is stable while its toggle crosses
  always_comb
  begin
    is_mode  = cmd[6:5] == `LCSD_OP2_MODE;
    is_addr  = cmd[6:5] == `LCSD_OP2_ADDR;
    is_drive = cmd[6:5] == `LCSD_OP2_DRIVE;
    is_setup = cmd[6:3] == `LCSD_OP4_SETUP;
    is_blink = cmd[6:3] == `LCSD_OP4_BLINK;
    is_pixel = cmd[6:2] == `LCSD_OP5_PIXEL;
    sw_reset = is_setup & cmd[`LCSD_BIT_SW_RESET];
  end

  // next state: synchronisers, command effects, ram writes, pixels
  always_comb
  begin
    n      = s;
    n.tg1  = ev_toggle;
    n.tg2  = s.tg1;
    n.tg3  = s.tg2;
    n.inh1 = DISPLAY_INHIBIT_N;
    n.inh2 = s.inh1;

    if (cmd_ev)
    begin
      if (sw_reset)
      begin
        // settings and address back to reset values, ram kept
        n.disp_on   = 1'b0;
        n.bias_half = 1'b0;
        n.rate      = `LCSD_RST_RATE;
        n.invert    = 1'b0;
        n.power     = `LCSD_RST_POWER;
        n.addr_msb  = 1'b0;
        n.ext_clk   = 1'b0;
        n.blink     = `LCSD_RST_BLINK;
        n.all_on    = 1'b0;
        n.all_off   = 1'b0;
        n.addr      = `LCSD_FIRST_ADDR;
      end
      else if (is_mode)
      begin
        // display on/off and bias
        n.disp_on   = cmd[`LCSD_BIT_DISP_ON];
        n.bias_half = cmd[`LCSD_BIT_BIAS];
      end
      else if (is_addr)
      begin
        // low five bits from command, top bit from setup
        n.addr = {s.addr_msb, cmd[4:0]};
      end
      else if (is_drive)
      begin
        // frame rate, waveform and drive power
        n.rate   = cmd[4:3];
        n.invert = cmd[`LCSD_BIT_INVERT];
        n.power  = cmd[1:0];
      end
      else if (is_setup)
      begin
        // address top bit and display clock source
        n.addr_msb = cmd[`LCSD_BIT_ADDR_MSB];
        n.ext_clk  = cmd[`LCSD_BIT_EXT_CLK];
      end
      else if (is_blink)
      begin
        // blink rate code
        n.blink = cmd[1:0];
      end
      else if (is_pixel)
      begin
        // force flags for every pixel
        n.all_on  = cmd[`LCSD_BIT_ALL_ON];
        n.all_off = cmd[`LCSD_BIT_ALL_OFF];
      end
    end
    else if (nib_ev)
    begin
      // every address below the depth is writable, pinned or not
      if (s.addr < 6'(`LCSD_RAM_DEPTH))
      begin
        n.ram[s.addr] = cmd[3:0];
      end
      // advance one per nibble, wrapping after the last address
      if (s.addr >= `LCSD_LAST_ADDR)
      begin
        n.addr = `LCSD_FIRST_ADDR;
      end
      else
      begin
        n.addr = s.addr + 6'h01;
      end
    end

    // pixel image: inhibit and display off blank, all-off beats all-on
    for (int i = 0; i < `LCSD_RAM_DEPTH; i++)
    begin
      if (!s.inh2 || !s.disp_on || s.all_off)
      begin
        n.pixel[i*4 +: 4] = 4'h0;
      end
      else if (s.all_on)
      begin
        n.pixel[i*4 +: 4] = 4'hf;
      end
      else
      begin
        n.pixel[i*4 +: 4] = s.ram[i];
      end
    end
  end

  // core register, reset to documented defaults
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s           <= '0;
      s.rate      <= `LCSD_RST_RATE;
      s.power     <= `LCSD_RST_POWER;
      s.blink     <= `LCSD_RST_BLINK;
      s.addr      <= `LCSD_FIRST_ADDR;
    end
    else
    begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign PIXEL           = s.pixel;
  assign DISPLAY_ON      = s.disp_on;
  assign BIAS_HALF       = s.bias_half;
  assign FRAME_RATE      = s.rate;
  assign FRAME_INVERSION = s.invert;
  assign POWER_MODE      = s.power;
  assign EXT_CLOCK_SEL   = s.ext_clk;
  assign BLINK_RATE      = s.blink;
  assign RAM_ADDRESS     = s.addr;

  // checks on the core clock
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  blank_on_inhibit_a: assert property (!s.inh2 |=> PIXEL == '0)
    else $error("pixels not blank while inhibited");

  mode_set_a: assert property (cmd_ev && is_mode && !sw_reset |=>
      DISPLAY_ON == $past(cmd[3]) && BIAS_HALF == $past(cmd[2]))
    else $error("mode command not applied");

  addr_load_a: assert property (cmd_ev && is_addr |=>
      RAM_ADDRESS == {$past(s.addr_msb), $past(cmd[4:0])})
    else $error("address load wrong");

  drive_ctl_a: assert property (cmd_ev && is_drive |=>
      FRAME_RATE == $past(cmd[4:3]) && POWER_MODE == $past(cmd[1:0]))
    else $error("drive command not applied");

  soft_reset_a: assert property (cmd_ev && sw_reset |=>
      !DISPLAY_ON && RAM_ADDRESS == 6'h00 && POWER_MODE == 2'h2 && $stable(s.ram))
    else $error("software reset wrong");

  addr_wrap_a: assert property (nib_ev && s.addr == 6'h22 |=> RAM_ADDRESS == 6'h00)
    else $error("address did not wrap");

  addr_step_a: assert property (nib_ev && s.addr < 6'h22 |=>
      RAM_ADDRESS == $past(s.addr) + 6'h01)
    else $error("address did not advance");

  all_off_wins_a: assert property (s.all_off ##1 s.all_off |-> PIXEL == '0)
    else $error("all-off not obeyed");

  // settings move only with their own command or a software reset
  invert_set_a: assert property (cmd_ev && is_drive |=>
      FRAME_INVERSION == $past(cmd[2]))
    else $error("frame inversion not applied");

  rate_keep_a: assert property (cmd_ev && !is_drive && !sw_reset |=>
      $stable(FRAME_RATE))
    else $error("frame rate changed by another command");

  power_keep_a: assert property (cmd_ev && !is_drive && !sw_reset |=>
      $stable(POWER_MODE))
    else $error("power mode changed by another command");

  mode_keep_a: assert property (cmd_ev && !is_mode && !sw_reset |=>
      $stable(DISPLAY_ON) && $stable(BIAS_HALF))
    else $error("display mode changed by another command");

  msb_keep_a: assert property (cmd_ev && is_addr |=>
      $stable(s.addr_msb))
    else $error("address load touched the top bit");

  addr_msb_a: assert property (cmd_ev && is_setup && !sw_reset |=>
      s.addr_msb == $past(cmd[2]))
    else $error("address top bit not stored");

  clock_src_a: assert property (cmd_ev && is_setup && !sw_reset |=>
      EXT_CLOCK_SEL == $past(cmd[0]))
    else $error("clock source not applied");

  blink_set_a: assert property (cmd_ev && is_blink |=>
      BLINK_RATE == $past(cmd[1:0]))
    else $error("blink rate not applied");

  force_set_a: assert property (cmd_ev && is_pixel |=>
      s.all_on == $past(cmd[1]) && s.all_off == $past(cmd[0]))
    else $error("all-pixel flags not applied");

  reset_settings_a: assert property (cmd_ev && sw_reset |=>
      !BIAS_HALF && FRAME_RATE == 2'h0 && !FRAME_INVERSION && !EXT_CLOCK_SEL && BLINK_RATE == 2'h0 && !s.addr_msb)
    else $error("software reset left a setting");

  settings_hold_a: assert property (!cmd_ev |=>
      $stable(DISPLAY_ON) && $stable(FRAME_RATE) && $stable(POWER_MODE) && $stable(BLINK_RATE))
    else $error("setting changed without a command");

  // write address and display ram
  addr_hold_a: assert property (!cmd_ev && !nib_ev |=>
      $stable(RAM_ADDRESS))
    else $error("address moved without a nibble");

  addr_move_a: assert property (nib_ev |=>
      RAM_ADDRESS != $past(RAM_ADDRESS))
    else $error("address stood still after a nibble");

  addr_guard_a: assert property (nib_ev && s.addr > 6'h22 |=>
      RAM_ADDRESS == 6'h00)
    else $error("address past the end did not return to zero");

  ram_write_a: assert property (nib_ev && s.addr < 6'h23 |=>
      s.ram[$past(s.addr)] == $past(cmd[3:0]))
    else $error("nibble not stored at its address");

  ram_dummy_a: assert property (nib_ev && s.addr > 6'h22 |=>
      $stable(s.ram))
    else $error("nibble stored past the last address");

  ram_hold_a: assert property (!nib_ev |=>
      $stable(s.ram))
    else $error("display ram changed without a nibble");

  // pixel image
  display_off_a: assert property (!s.disp_on |=>
      PIXEL == '0)
    else $error("pixels lit while display off");

  all_on_a: assert property (s.inh2 && s.disp_on && !s.all_off && s.all_on |=>
      PIXEL == {140{1'b1}})
    else $error("all-on not obeyed");

  ram_to_seg_a: assert property (s.inh2 && s.disp_on && !s.all_off && !s.all_on |=>
      PIXEL == $past(s.ram))
    else $error("pixels do not follow the ram");

  // hand-over from the link clock
  one_event_a: assert property (ev |=>
      !ev)
    else $error("hand-over event longer than one cycle");

  word_stable_a: assert property (ev |=>
      $stable(ev_data) && $stable(ev_is_cmd))
    else $error("hand-over word changed right after its event");

endmodule

// ===== test/lcsd_host.sv
`timescale 1ns/1ps

// host model: drives the three-wire write link, flag bit first
module lcsd_host
(
  output logic scl,
  output logic cs_n,
  output logic serial_data_in
);
  int gap = 0;  // extra setup time per bit, for a slow host

  // link idle: clock stands still, link deselected
  initial
  begin
    scl = 1'b0;
    cs_n = 1'b1;
    serial_data_in = 1'b0;
  end

  // open a frame; the bit counter leaves its idle state only now
  task automatic select();
    cs_n = 1'b0;
    #6;
  endtask

  // shift nbits of one byte out, msb first, data set up before scl rises
  task automatic send(input logic [7:0] b, input int nbits);
    for (int i = 7; i > 7 - nbits; i--)
    begin
      serial_data_in = b[i];
      #(3 + gap);
      scl = 1'b1;
      #3;
      scl = 1'b0;
    end
  endtask

  // close the frame; the released data line no longer shows the last bit
  task automatic release_link();
    #3;
    cs_n = 1'b1;
    serial_data_in = ~serial_data_in;
  endtask
endmodule

// ===== test/lcsd_top_bench.sv
`timescale 1ns/1ps

// self-checking bench for the serial lcd command block
module lcsd_top_bench;
  logic         MCLK = 1'b0;              // core clock, 5 ns
  logic         RST_N = 1'b0;             // async reset, low active
  logic         DISPLAY_INHIBIT_N = 1'b1; // blanking input
  logic         SCL;                      // link clock from host
  logic         CS_N;                     // link select from host
  logic         SERIAL_DATA_IN;           // link data from host
  logic [139:0] PIXEL;                    // segment and common image
  logic [9:0]   status;                   // on, bias, rate, inv, power, ext, blink
  logic [5:0]   RAM_ADDRESS;              // current write address
  int           fail_count = 0;           // mismatches seen
  int           samples_checked = 0;      // comparisons made

  // command byte beside the settings it should leave behind
  localparam logic [17:0] ROWS [13] = '{
    {8'hC8, 10'b1000010000}, {8'hC4, 10'b0100010000}, {8'hCC, 10'b1100010000},
    {8'hAB, 10'b1101011000}, {8'hB4, 10'b1110100000}, {8'hBD, 10'b1111101000},
    {8'hE9, 10'b1111101100}, {8'hF1, 10'b1111101101}, {8'hF2, 10'b1111101110},
    {8'hF7, 10'b1111101111}, {8'hE8, 10'b1111101011}, {8'hF0, 10'b1111101000},
    {8'hEA, 10'b0000010000}};

  lcsd_host host (.scl(SCL), .cs_n(CS_N), .serial_data_in(SERIAL_DATA_IN));

  lcsd_top DUT (
    .MCLK(MCLK), .RST_N(RST_N), .SERIAL_CLOCK(SCL), .CHIP_SELECT_N(CS_N),
    .SERIAL_DATA_IN(SERIAL_DATA_IN), .DISPLAY_INHIBIT_N(DISPLAY_INHIBIT_N), .PIXEL(PIXEL),
    .DISPLAY_ON(status[9]), .BIAS_HALF(status[8]), .FRAME_RATE(status[7:6]),
    .FRAME_INVERSION(status[5]), .POWER_MODE(status[4:3]), .EXT_CLOCK_SEL(status[2]),
    .BLINK_RATE(status[1:0]), .RAM_ADDRESS(RAM_ADDRESS));

  // core clock
  always #2.5 MCLK = ~MCLK;

  // compare one value, count it, report a mismatch
  task automatic check(input logic [139:0] seen, input logic [139:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // counts, verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one link frame of whole bytes, the last cut to tail bits; then let it cross
  task automatic frame(input logic [7:0] b[$], input int tail);
    host.select();
    foreach (b[i])
      host.send(b[i], (i == b.size() - 1) ? tail : 8);
    host.release_link();
    repeat (8) @(negedge MCLK);
  endtask

  // reset for 10 cycles, outputs checked while it is held
  task automatic do_reset();
    @(negedge MCLK);
    RST_N = 1'b0;
    repeat (10) @(negedge MCLK);
    check(status, 10'h010);
    check(RAM_ADDRESS, 6'h00);
    check(PIXEL, 140'h0);
    RST_N = 1'b1;
    repeat (2) @(negedge MCLK);
  endtask

  // hang guard
  initial
  begin
    #100000;
    fail_count++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    do_reset();
    foreach (ROWS[i])
    begin
      frame('{ROWS[i][17:10]}, 8);
      check(status, ROWS[i][9:0]);
    end
    check(RAM_ADDRESS, 6'h00);
    // address 0, then one data byte split over two nibbles
    frame('{8'hC8, 8'h00, 8'hA5}, 8);
    check(PIXEL[7:0], 8'h5A);
    check(RAM_ADDRESS, 6'h02);
    // top address through the setup bit, slow host, wrap to zero
    host.gap = 12;
    frame('{8'hEC, 8'h02, 8'h3C}, 8);
    host.gap = 0;
    check({PIXEL[139:136], PIXEL[3:0]}, 8'h3C);
    check(RAM_ADDRESS, 6'h01);
    // deselect then software reset, then a byte cut after six bits
    frame('{8'hEA, 8'hC8, 8'h01, 8'h9F}, 6);
    check(PIXEL[11:0], 12'h09C);
    check(RAM_ADDRESS, 6'h02);
    // a half command is dropped
    frame('{8'hC0}, 4);
    check(status[9], 1'b1);
    frame('{8'hFE}, 8);
    check(PIXEL, {140{1'b1}});
    frame('{8'hFF}, 8);
    check(PIXEL, 140'h0);
    frame('{8'hFC}, 8);
    check(PIXEL[11:0], 12'h09C);
    DISPLAY_INHIBIT_N = 1'b0;
    repeat (4) @(negedge MCLK);
    check(PIXEL, 140'h0);
    DISPLAY_INHIBIT_N = 1'b1;
    repeat (4) @(negedge MCLK);
    check(PIXEL[11:0], 12'h09C);
    // an address past the last one: that nibble is dropped, the next lands at zero
    frame('{8'hEC, 8'h03, 8'h75}, 8);
    check(PIXEL, {4'h3, 124'h0, 12'h095});
    check(RAM_ADDRESS, 6'h01);
    frame('{8'hC0}, 8);
    check(PIXEL, 140'h0);
    // second reset in mid-run
    do_reset();
    end_of_test();
  end
endmodule
